/* design/adc_route_decode.sv */
// Registered decode of selection fields into analog switch controls.
// Assumes fields come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_src_defines.svh"

module adc_route_decode (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Selection fields
  input  wire logic [3:0]            input_source_sel_i,
  input  wire logic [3:0]            ext_channel_sel_i,
  input  wire logic [1:0]            ref_source_sel_i,
  input  wire logic                  amp_input_sel_i,
  // Switch controls
  output adc_src_pkg::conv_src_t     conv_src_o,
  output logic [`NUM_PINS-1:0]       chan_sw_o,
  output adc_src_pkg::ref_src_t      ref_src_o,
  output logic                       vref_pin_sw_o,
  output logic                       amp_ref_input_pin_pin_sw_o,
  output logic                       bg_to_amp_sw_o
);

  // ========================================================================
  // Decode
  function automatic logic is_ext_code(input logic [3:0] code);
    is_ext_code = (code == `IN_EXT_A) || (code == `IN_EXT_B) ||
                  (code[3:2] == `IN_TOP2_EXT);
  endfunction

  wire logic ext_sel = is_ext_code(input_source_sel_i);
  wire logic ch_valid = (ext_channel_sel_i >= `CH_FIRST) &&
                        (ext_channel_sel_i <= `CH_LAST);
  wire logic [3:0] ch_idx = ext_channel_sel_i - `CH_FIRST;

  logic [`NUM_PINS-1:0] chan_nxt;
  adc_src_pkg::conv_src_t src_nxt;

  always_comb begin
    chan_nxt = '0;
    if (ext_sel && ch_valid) begin
      chan_nxt[ch_idx[2:0]] = 1'b1;
    end
  end
  // Internal codes leave chan_nxt all open: no short onto an external pin

  always_comb begin
    case (input_source_sel_i)
      `IN_AVDD:   src_nxt = adc_src_pkg::SRC_AVDD;
      `IN_AVDD_2: src_nxt = adc_src_pkg::SRC_AVDD_2;
      `IN_AVDD_4: src_nxt = adc_src_pkg::SRC_AVDD_4;
      `IN_VR:     src_nxt = adc_src_pkg::SRC_VR;
      `IN_VR_2:   src_nxt = adc_src_pkg::SRC_VR_2;
      `IN_VR_4:   src_nxt = adc_src_pkg::SRC_VR_4;
      default: begin
        if (input_source_sel_i[3:2] == `IN_TOP2_GND) begin
          src_nxt = adc_src_pkg::SRC_GND;
        end else if (ch_valid) begin
          src_nxt = adc_src_pkg::SRC_EXT;
        end else begin
          src_nxt = adc_src_pkg::SRC_FLOAT;
        end
      end
    endcase
  end

  wire adc_src_pkg::ref_src_t ref_nxt =
    ref_source_sel_i[1]            ? adc_src_pkg::REFSRC_AMP :
    (ref_source_sel_i == `REF_EXT_PIN) ? adc_src_pkg::REFSRC_PIN :
                                     adc_src_pkg::REFSRC_AVDD;

  // ========================================================================
  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_src_o     <= adc_src_pkg::SRC_FLOAT;
      chan_sw_o      <= '0;
      ref_src_o      <= adc_src_pkg::REFSRC_AVDD;
      vref_pin_sw_o  <= 1'b0;
      amp_ref_input_pin_pin_sw_o <= 1'b1;
      bg_to_amp_sw_o <= 1'b0;
    end else begin
      conv_src_o     <= src_nxt;
      chan_sw_o      <= chan_nxt;
      ref_src_o      <= ref_nxt;
      vref_pin_sw_o  <= (ref_source_sel_i == `REF_EXT_PIN);
      amp_ref_input_pin_pin_sw_o <= ~amp_input_sel_i;
      bg_to_amp_sw_o <= amp_input_sel_i;
    end
  end

endmodule
`default_nettype wire

/* design/adc_source_reference_select.sv */
// Converter source and reference selection with a Wishbone register file.
// Assumes a classic Wishbone master on clk_i; analog switches lie outside.
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_src_defines.svh"

module adc_source_reference_select (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // Converter input routing
  output adc_src_pkg::conv_src_t     conv_src_o,
  output logic [`NUM_PINS-1:0]       chan_sw_o,
  // Reference routing and amplifier
  output adc_src_pkg::ref_src_t      ref_src_o,
  output logic                       vref_pin_sw_o,
  output logic                       amp_ref_input_pin_pin_sw_o,
  output logic                       bg_to_amp_sw_o,
  output logic                       ref_amp_enable_o,
  output logic [1:0]                 amp_gain_sel_o,
  output logic                       bandgap_enable_o,
  // Shared analog pins
  input  wire logic [`NUM_PINS-1:0]  pin_in_i,
  output logic [`NUM_PINS-1:0]       pin_out_o,
  output logic [`NUM_PINS-1:0]       pin_oe_o,
  output logic [`NUM_PINS-1:0]       pin_pullup_o,
  output logic [`NUM_PINS-1:0]       pin_alt_en_o,
  output logic [`NUM_PINS-1:0]       pin_analog_o
);

  // ========================================================================
  // Registers
  logic [3:0]            ext_channel_sel_r;
  logic [3:0]            input_source_sel_r;
  logic                  ref_amp_enable_r;
  logic                  amp_input_sel_r;
  logic [1:0]            ref_source_sel_r;
  logic [1:0]            amp_gain_sel_r;
  logic                  bandgap_enable_r;
  logic [`NUM_PINS-1:0]  pin_func_sel_lo_r;
  logic [`NUM_PINS-1:0]  pin_func_sel_hi_r;
  logic [`NUM_PINS-1:0]  pullup_en_r;
  logic [`NUM_PINS-1:0]  port_dir_r;
  logic [`NUM_PINS-1:0]  port_out_r;
  logic [`NUM_PINS-1:0]  pin_meta_r;
  logic [`NUM_PINS-1:0]  pin_sync_r;
  logic                  ack_r;
  logic [31:0]           dat_r;

  // ========================================================================
  // Bus decode
  // Only lane 0 carries data; a write without sel_i[0] changes nothing.
  wire logic       req     = cyc_i && stb_i && !ack_r;
  wire logic       wr_lane = req && we_i && sel_i[0];
  wire logic [7:0] wb      = dat_i[7:0];

  wire logic wr_cc0  = wr_lane && (adr_i == `OFS_CONV_CONTROL_0);
  wire logic wr_cc1  = wr_lane && (adr_i == `OFS_CONV_CONTROL_1);
  wire logic wr_cc2  = wr_lane && (adr_i == `OFS_CONV_CONTROL_2);
  wire logic wr_bg   = wr_lane && (adr_i == `OFS_BANDGAP_REF_CTRL);
  wire logic wr_pflo = wr_lane && (adr_i == `OFS_PIN_FUNC_SEL_LO);
  wire logic wr_pfhi = wr_lane && (adr_i == `OFS_PIN_FUNC_SEL_HI);
  wire logic wr_pu   = wr_lane && (adr_i == `OFS_PULLUP_EN);
  wire logic wr_dir  = wr_lane && (adr_i == `OFS_PORT_DIR);
  wire logic wr_out  = wr_lane && (adr_i == `OFS_PORT_OUT);

  // ========================================================================
  // Pin function decode
  logic [`NUM_PINS-1:0] is_analog;
  logic [`NUM_PINS-1:0] is_gpio;
  logic [`NUM_PINS-1:0] is_alt;

  genvar g;
  generate
    for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_pin
      wire logic [1:0] code = {pin_func_sel_hi_r[g], pin_func_sel_lo_r[g]};
      assign is_analog[g] = (code == `PFS_ANALOG);
      assign is_gpio[g]   = (code == `PFS_GPIO);
      assign is_alt[g]    = !is_analog[g] && !is_gpio[g];
    end
  endgenerate

  // Analog pins ignore direction, pull-up and GPIO data
  wire logic [`NUM_PINS-1:0] oe_nxt  = port_dir_r & is_gpio;
  wire logic [`NUM_PINS-1:0] pu_nxt  = pullup_en_r & ~is_analog;
  wire logic [`NUM_PINS-1:0] out_nxt = port_out_r & is_gpio;
  wire logic [`NUM_PINS-1:0] in_vis  = pin_sync_r & is_gpio;

  // ========================================================================
  // Read data
  logic [7:0] rd_byte;
  logic       hit;

  always_comb begin
    rd_byte = 8'h00;
    hit     = 1'b1;
    case (adr_i)
      `OFS_CONV_CONTROL_0: begin
        rd_byte[`CH_SEL_MSB:`CH_SEL_LSB] = ext_channel_sel_r;
      end
      `OFS_CONV_CONTROL_1: begin
        rd_byte[`IN_SEL_MSB:`IN_SEL_LSB] = input_source_sel_r;
      end
      `OFS_CONV_CONTROL_2: begin
        rd_byte[`AMP_EN_BIT]                 = ref_amp_enable_r;
        rd_byte[`AMP_IN_BIT]                 = amp_input_sel_r;
        rd_byte[`REF_SEL_MSB:`REF_SEL_LSB]   = ref_source_sel_r;
        rd_byte[`GAIN_MSB:`GAIN_LSB]         = amp_gain_sel_r;
      end
      `OFS_BANDGAP_REF_CTRL: begin
        rd_byte[`BG_EN_BIT] = bandgap_enable_r;
      end
      `OFS_PIN_FUNC_SEL_LO: begin
        rd_byte[`NUM_PINS-1:0] = pin_func_sel_lo_r;
      end
      `OFS_PIN_FUNC_SEL_HI: begin
        rd_byte[`NUM_PINS-1:0] = pin_func_sel_hi_r;
      end
      `OFS_PULLUP_EN: begin
        rd_byte[`NUM_PINS-1:0] = pullup_en_r;
      end
      `OFS_PORT_DIR: begin
        rd_byte[`NUM_PINS-1:0] = port_dir_r;
      end
      `OFS_PORT_OUT: begin
        rd_byte[`NUM_PINS-1:0] = port_out_r;
      end
      `OFS_PORT_IN: begin
        rd_byte[`NUM_PINS-1:0] = in_vis;
      end
      `OFS_ROUTE_STATUS: begin
        // Live switch state as driven to the analog side
        rd_byte = {conv_src_o, vref_pin_sw_o, amp_ref_input_pin_pin_sw_o, ref_src_o};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Unmapped addresses still acknowledge, reading zero
  wire logic [31:0] rd_word = hit ? {24'h000000, rd_byte} : 32'h00000000;

  // ========================================================================
  // Wishbone handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req;
      dat_r <= (req && !we_i) ? rd_word : 32'h00000000;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ========================================================================
  // Selection registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_channel_sel_r  <= `RST_FIELD4;
      input_source_sel_r <= `RST_FIELD4;
    end else begin
      if (wr_cc0) begin
        ext_channel_sel_r <= wb[`CH_SEL_MSB:`CH_SEL_LSB];
      end
      if (wr_cc1) begin
        input_source_sel_r <= wb[`IN_SEL_MSB:`IN_SEL_LSB];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_amp_enable_r <= `RST_BIT;
      amp_input_sel_r  <= `RST_BIT;
      ref_source_sel_r <= `RST_FIELD2;
      amp_gain_sel_r   <= `RST_FIELD2;
    end else if (wr_cc2) begin
      ref_amp_enable_r <= wb[`AMP_EN_BIT];
      amp_input_sel_r  <= wb[`AMP_IN_BIT];
      ref_source_sel_r <= wb[`REF_SEL_MSB:`REF_SEL_LSB];
      amp_gain_sel_r   <= wb[`GAIN_MSB:`GAIN_LSB];
    end
  end

  // Upper write bits are dropped here, so nothing else to store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bandgap_enable_r <= `RST_BIT;
    end else if (wr_bg) begin
      bandgap_enable_r <= wb[`BG_EN_BIT];
    end
  end

  // ========================================================================
  // Pin control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_func_sel_lo_r <= `RST_PINS;
      pin_func_sel_hi_r <= `RST_PINS;
      pullup_en_r       <= `RST_PINS;
      port_dir_r        <= `RST_PINS;
      port_out_r        <= `RST_PINS;
    end else begin
      if (wr_pflo) begin
        pin_func_sel_lo_r <= wb[`NUM_PINS-1:0];
      end
      if (wr_pfhi) begin
        pin_func_sel_hi_r <= wb[`NUM_PINS-1:0];
      end
      if (wr_pu) begin
        pullup_en_r <= wb[`NUM_PINS-1:0];
      end
      if (wr_dir) begin
        port_dir_r <= wb[`NUM_PINS-1:0];
      end
      if (wr_out) begin
        port_out_r <= wb[`NUM_PINS-1:0];
      end
    end
  end

  // Pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= `RST_PINS;
      pin_sync_r <= `RST_PINS;
    end else begin
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ========================================================================
  // Registered pin and analog control outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o        <= `RST_PINS;
      pin_oe_o         <= `RST_PINS;
      pin_pullup_o     <= `RST_PINS;
      pin_alt_en_o     <= `RST_PINS;
      pin_analog_o     <= `RST_PINS;
      ref_amp_enable_o <= `RST_BIT;
      amp_gain_sel_o   <= `RST_FIELD2;
      bandgap_enable_o <= `RST_BIT;
    end else begin
      pin_out_o        <= out_nxt;
      pin_oe_o         <= oe_nxt;
      pin_pullup_o     <= pu_nxt;
      pin_alt_en_o     <= is_alt;
      pin_analog_o     <= is_analog;
      ref_amp_enable_o <= ref_amp_enable_r;
      amp_gain_sel_o   <= amp_gain_sel_r;
      bandgap_enable_o <= bandgap_enable_r;
    end
  end

  // ========================================================================
  // Analog routing
  adc_route_decode u_route (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .input_source_sel_i (input_source_sel_r),
    .ext_channel_sel_i  (ext_channel_sel_r),
    .ref_source_sel_i   (ref_source_sel_r),
    .amp_input_sel_i    (amp_input_sel_r),
    .conv_src_o         (conv_src_o),
    .chan_sw_o          (chan_sw_o),
    .ref_src_o          (ref_src_o),
    .vref_pin_sw_o      (vref_pin_sw_o),
    .amp_ref_input_pin_pin_sw_o     (amp_ref_input_pin_pin_sw_o),
    .bg_to_amp_sw_o     (bg_to_amp_sw_o)
  );

endmodule
`default_nettype wire

/* design/adc_src_defines.svh */
// Constants for the converter source and reference selection block.
// Assumes inclusion by bare name from design and bench files.
`ifndef ADC_SRC_DEFINES_SVH
`define ADC_SRC_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define OFS_CONV_CONTROL_0     8'h00
`define OFS_CONV_CONTROL_1     8'h04
`define OFS_CONV_CONTROL_2     8'h08
`define OFS_BANDGAP_REF_CTRL   8'h0C
`define OFS_PIN_FUNC_SEL_LO    8'h10
`define OFS_PIN_FUNC_SEL_HI    8'h14
`define OFS_PULLUP_EN          8'h18
`define OFS_PORT_DIR           8'h1C
`define OFS_PORT_OUT           8'h20
`define OFS_PORT_IN            8'h24
`define OFS_ROUTE_STATUS       8'h28

// ==========================================================================
// Field positions
`define CH_SEL_LSB             0
`define CH_SEL_MSB             3
`define IN_SEL_LSB             4
`define IN_SEL_MSB             7
`define GAIN_LSB               0
`define GAIN_MSB               1
`define REF_SEL_LSB            2
`define REF_SEL_MSB            3
`define AMP_IN_BIT             4
`define AMP_EN_BIT             7
`define BG_EN_BIT              0

// ==========================================================================
// Reset values
`define RST_FIELD4             4'h0
`define RST_FIELD2             2'h0
`define RST_BIT                1'b0
`define RST_PINS               5'h00

// ==========================================================================
// Codes
`define CH_FIRST               4'h3
`define CH_LAST                4'h7
`define IN_EXT_A               4'h0
`define IN_EXT_B               4'h4
`define IN_AVDD                4'h1
`define IN_AVDD_2              4'h2
`define IN_AVDD_4              4'h3
`define IN_VR                  4'h5
`define IN_VR_2                4'h6
`define IN_VR_4                4'h7
`define IN_TOP2_GND            2'h2
`define IN_TOP2_EXT            2'h3
`define REF_AVDD               2'h0
`define REF_EXT_PIN            2'h1
`define PFS_ANALOG             2'h3
`define PFS_GPIO               2'h0
`define NUM_PINS               5

`endif

/* design/adc_src_pkg.sv */
// Types shared by the converter source and reference selection files.
// Assumes the defines header is compiled alongside.
package adc_src_pkg;

  // Source presented to the converter input
  typedef enum logic [3:0] {
    SRC_FLOAT  = 4'h0,
    SRC_EXT    = 4'h1,
    SRC_AVDD   = 4'h2,
    SRC_AVDD_2 = 4'h3,
    SRC_AVDD_4 = 4'h4,
    SRC_VR     = 4'h5,
    SRC_VR_2   = 4'h6,
    SRC_VR_4   = 4'h7,
    SRC_GND    = 4'h8
  } conv_src_t;

  // Source presented to the converter reference
  typedef enum logic [1:0] {
    REFSRC_AVDD = 2'h0,
    REFSRC_PIN  = 2'h1,
    REFSRC_AMP  = 2'h2
  } ref_src_t;

endpackage

/* tb/adc_source_reference_select_tb.sv */
// Self-checking bench for the source and reference selection block.
// Assumes package, header, design and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "adc_src_defines.svh"

module adc_source_reference_select_tb;
  // ==========================================================================
  // Signals
  logic                   clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic                   vref_pin_sw_o, amp_ref_input_pin_pin_sw_o, bg_to_amp_sw_o;
  logic                   ref_amp_enable_o, bandgap_enable_o;
  logic [1:0]             amp_gain_sel_o;
  logic [3:0]             sel_i;
  logic [7:0]             adr_i;
  logic [31:0]            dat_i, dat_o;
  logic [`NUM_PINS-1:0]   chan_sw_o, pin_in_i, pin_out_o, pin_oe_o;
  logic [`NUM_PINS-1:0]   pin_pullup_o, pin_alt_en_o, pin_analog_o;
  adc_src_pkg::conv_src_t conv_src_o;
  adc_src_pkg::ref_src_t  ref_src_o;
  int                     n_errors, num_checks, cycles;

  adc_source_reference_select DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .conv_src_o(conv_src_o), .chan_sw_o(chan_sw_o), .ref_src_o(ref_src_o),
    .vref_pin_sw_o(vref_pin_sw_o), .amp_ref_input_pin_pin_sw_o(amp_ref_input_pin_pin_sw_o),
    .bg_to_amp_sw_o(bg_to_amp_sw_o), .ref_amp_enable_o(ref_amp_enable_o),
    .amp_gain_sel_o(amp_gain_sel_o), .bandgap_enable_o(bandgap_enable_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .pin_alt_en_o(pin_alt_en_o), .pin_analog_o(pin_analog_o)
  );

  // ==========================================================================
  // Helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic cycle; starts and ends just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= s;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(nm, q, exp);
  endtask

  // Expected {source, channel switches}; codes 11xx are external too
  function automatic logic [8:0] route_exp(input logic [3:0] s, input logic [3:0] ch);
    logic ext;
    ext = (ch >= 4'h3) && (ch <= 4'h7);
    case (s)
      4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF:
        route_exp = ext ? {4'h1, 5'h01 << (ch - 4'h3)} : 9'h000;
      4'h1, 4'h2, 4'h3: route_exp = {s + 4'h1, 5'h00};
      4'h5, 4'h6, 4'h7: route_exp = {s, 5'h00};
      4'h8, 4'h9, 4'hA, 4'hB: route_exp = {4'h8, 5'h00};
      default: route_exp = 9'h000;
    endcase
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check("route", 32'({conv_src_o, chan_sw_o}), 32'h0);
    check("refpath", 32'({ref_src_o, vref_pin_sw_o, amp_ref_input_pin_pin_sw_o, bg_to_amp_sw_o,
          ref_amp_enable_o, amp_gain_sel_o, bandgap_enable_o}), 32'h020);
    check("pins", 32'({pin_oe_o, pin_pullup_o, pin_alt_en_o, pin_analog_o}), 32'h0);
    rd_chk("ctrl2", `OFS_CONV_CONTROL_2, 32'h0);
    rd_chk("bgctl", `OFS_BANDGAP_REF_CTRL, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_bgap();
    logic [31:0] q;
    wr(`OFS_BANDGAP_REF_CTRL, 32'h000000FF);
    check("bgen", 32'(bandgap_enable_o), 32'h1);
    rd_chk("bgctl", `OFS_BANDGAP_REF_CTRL, 32'h1);
    wb(1'b1, `OFS_BANDGAP_REF_CTRL, 32'h00000000, 4'hE, q);
    check("bgen_lane", 32'(bandgap_enable_o), 32'h1);
    wr(`OFS_BANDGAP_REF_CTRL, 32'h000000FE);
    check("bgen", 32'(bandgap_enable_o), 32'h0);
    wr(8'h3C, 32'h000000FF);
    rd_chk("unmapped", 8'h3C, 32'h0);
    $display("test bandgap done");
  endtask

  task automatic t_ref();
    logic [1:0] c;
    logic [7:0] v;
    wr(`OFS_BANDGAP_REF_CTRL, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      v = {c[1], 2'b00, c[0], c, c};
      wr(`OFS_CONV_CONTROL_2, 32'(v));
      check("refpath", 32'({ref_src_o, vref_pin_sw_o, amp_ref_input_pin_pin_sw_o, bg_to_amp_sw_o,
            ref_amp_enable_o, amp_gain_sel_o}),
            32'({c[1] ? 2'h2 : c, c == 2'h1, ~c[0], c[0], c[1], c}));
      rd_chk("ctrl2", `OFS_CONV_CONTROL_2, 32'(v));
    end
    rd_chk("status", `OFS_ROUTE_STATUS, 32'h02);
    $display("test reference done");
  endtask

  task automatic t_input();
    logic [8:0] e;
    for (int ch = 0; ch < 16; ch++) begin
      wr(`OFS_CONV_CONTROL_0, 32'(ch));
      for (int s = 0; s < 16; s++) begin
        wr(`OFS_CONV_CONTROL_1, 32'(s << 4));
        e = route_exp(s[3:0], ch[3:0]);
        check("route", 32'({conv_src_o, chan_sw_o}), 32'(e));
      end
    end
    $display("test input done");
  endtask

  task automatic t_pins();
    wr(`OFS_PULLUP_EN, 32'h1F);
    wr(`OFS_PORT_DIR, 32'h1F);
    wr(`OFS_PORT_OUT, 32'h1F);
    wr(`OFS_PIN_FUNC_SEL_LO, 32'h1F);
    wr(`OFS_PIN_FUNC_SEL_HI, 32'h1F);
    check("pins", 32'({pin_oe_o, pin_pullup_o, pin_alt_en_o, pin_analog_o, pin_out_o}),
          32'({5'h00, 5'h00, 5'h00, 5'h1F, 5'h00}));
    rd_chk("portin", `OFS_PORT_IN, 32'h0);
    wr(`OFS_PIN_FUNC_SEL_LO, 32'h05);
    wr(`OFS_PIN_FUNC_SEL_HI, 32'h03);
    check("pins", 32'({pin_oe_o, pin_pullup_o, pin_alt_en_o, pin_analog_o, pin_out_o}),
          32'({5'h18, 5'h1E, 5'h06, 5'h01, 5'h18}));
    rd_chk("portin", `OFS_PORT_IN, 32'h10);
    $display("test pins done");
  endtask

  // Mid-run reset after every field has been set away from zero
  task automatic t_rerst();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
  endtask

  // ==========================================================================
  // Run control
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole run needs about 900 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    rst_i    = 1'b1;
    cyc_i    = 1'b0;
    stb_i    = 1'b0;
    we_i     = 1'b0;
    adr_i    = 8'h00;
    sel_i    = 4'hF;
    dat_i    = 32'h0;
    pin_in_i = 5'h15;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_bgap();
    t_ref();
    t_input();
    t_pins();
    t_rerst();
    stop_test();
  end
endmodule

bind adc_source_reference_select adc_src_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conv_src_o(conv_src_o),
  .chan_sw_o(chan_sw_o), .ref_src_o(ref_src_o), .vref_pin_sw_o(vref_pin_sw_o),
  .amp_ref_input_pin_pin_sw_o(amp_ref_input_pin_pin_sw_o), .bg_to_amp_sw_o(bg_to_amp_sw_o),
  .amp_gain_sel_o(amp_gain_sel_o), .bandgap_enable_o(bandgap_enable_o),
  .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .pin_alt_en_o(pin_alt_en_o),
  .pin_analog_o(pin_analog_o)
);
`default_nettype wire

/* tb/adc_src_checker_asserts.sv */
// Concurrent checks on the ports of the source and reference selection block.
// Assumes a bind to the top module; everything sampled on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "adc_src_defines.svh"

module adc_src_checker (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Register bus
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  input  wire logic [31:0]            dat_o,
  input  wire logic                   ack_o,
  // Routing and pins
  input  wire adc_src_pkg::conv_src_t conv_src_o,
  input  wire logic [`NUM_PINS-1:0]   chan_sw_o,
  input  wire adc_src_pkg::ref_src_t  ref_src_o,
  input  wire logic                   vref_pin_sw_o,
  input  wire logic                   amp_ref_input_pin_pin_sw_o,
  input  wire logic                   bg_to_amp_sw_o,
  input  wire logic [1:0]             amp_gain_sel_o,
  input  wire logic                   bandgap_enable_o,
  input  wire logic [`NUM_PINS-1:0]   pin_oe_o,
  input  wire logic [`NUM_PINS-1:0]   pin_pullup_o,
  input  wire logic [`NUM_PINS-1:0]   pin_alt_en_o,
  input  wire logic [`NUM_PINS-1:0]   pin_analog_o
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire logic take_w;
  wire logic bg_wr_w;
  assign take_w  = cyc_i && stb_i && !ack_o;
  assign bg_wr_w = take_w && we_i && sel_i[0] && (adr_i == `OFS_BANDGAP_REF_CTRL);

  ack_once_a: assert property (take_w |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse after request");
  read_idle_a: assert property (dat_o[31:8] == 24'h0 && (ack_o || dat_o == 32'h0))
    else $error("read data not zero outside answer");
  ref_pin_sw_a: assert property (vref_pin_sw_o == (ref_src_o == adc_src_pkg::REFSRC_PIN))
    else $error("reference pin switch mismatch");
  amp_in_sw_a: assert property (amp_ref_input_pin_pin_sw_o != bg_to_amp_sw_o)
    else $error("amplifier input switches both open or both closed");
  int_src_open_a: assert property (conv_src_o != adc_src_pkg::SRC_EXT |-> chan_sw_o == '0)
    else $error("channel switch closed without external source");
  ext_onehot_a: assert property (conv_src_o == adc_src_pkg::SRC_EXT |-> $onehot(chan_sw_o))
    else $error("external source without one channel");
  analog_pin_a: assert property (
    (pin_analog_o & (pin_pullup_o | pin_oe_o | pin_alt_en_o)) == '0)
    else $error("analog pin keeps pull-up, drive or alternate");
  bg_write_a: assert property (bg_wr_w |=> ##1 bandgap_enable_o == $past(dat_i[0], 2))
    else $error("bandgap enable does not follow write");
  reset_zero_a: assert property (disable iff (1'b0) rst_i |=>
    conv_src_o == adc_src_pkg::SRC_FLOAT && ref_src_o == adc_src_pkg::REFSRC_AVDD
    && !bandgap_enable_o && amp_gain_sel_o == 2'h0)
    else $error("selection fields not cleared by reset");

  // ==========================================================================
  // Coverage
  bg_write_c: cover property (bg_wr_w);
  ext_src_c: cover property (conv_src_o == adc_src_pkg::SRC_EXT);
  gnd_src_c: cover property (conv_src_o == adc_src_pkg::SRC_GND);
  amp_ref_c: cover property (ref_src_o == adc_src_pkg::REFSRC_AMP);
endmodule
`default_nettype wire
